// *** shared/pha_pkg.sv ***
// Constants, register layout and timing for the processor-hot alert monitor
package pha_pkg;
   // Register command codes and reset values
   localparam logic [7:0] PHA_ADDR_THRESHOLDS = 8'h33;
   localparam logic [7:0] PHA_ADDR_PROFILE = 8'h34;
   localparam logic [15:0] PHA_RST_THRESHOLDS = 16'h4A54;
   localparam logic [15:0] PHA_RST_PROFILE = 16'h8120;
   // Field positions in hot_alert_thresholds
   localparam int PHA_OVL_LSB = 11;
   localparam int PHA_CRIT_DEG_LSB = 9;
   localparam int PHA_SYSTEM_VOLTAGE_LSB = 6;
   localparam int PHA_EXT_BIT = 5;
   localparam int PHA_WIDTH_LSB = 3;
   localparam int PHA_CLEAR_BIT = 2;
   localparam int PHA_NOM_DEG_BIT = 1;
   // Field positions in hot_alert_discharge_profile
   localparam int PHA_DCHG_VTH_LSB = 10;
   localparam int PHA_DCHG_DEG_LSB = 8;
   localparam int PHA_PROF_W = 7;
   localparam int PHA_P_COMP = 6;
   localparam int PHA_P_CRIT = 5;
   localparam int PHA_P_NOM = 4;
   localparam int PHA_P_DCHG = 3;
   localparam int PHA_P_SYSTEM_VOLTAGE = 2;
   localparam int PHA_P_BAT = 1;
   localparam int PHA_P_ACOK = 0;
   // Overload code map and percentages
   localparam logic [4:0] PHA_OVL_FINE_LAST = 5'h19;
   localparam logic [4:0] PHA_OVL_COARSE_FIRST = 5'h1A;
   localparam logic [4:0] PHA_OVL_OUT_OF_RANGE = 5'h1F;
   localparam logic [31:0] PHA_PCT_FINE_BASE = 32'h0000_006E;   // 110 %
   localparam logic [31:0] PHA_PCT_FINE_STEP = 32'h0000_0005;   // 5 %
   localparam logic [31:0] PHA_PCT_COARSE_BASE = 32'h0000_00FA; // 250 %
   localparam logic [31:0] PHA_PCT_COARSE_STEP = 32'h0000_0032; // 50 %
   localparam logic [31:0] PHA_PCT_CRIT = 32'h0000_006E;        // 110 % of overload
   localparam logic [31:0] PHA_PCT_NOM = 32'h0000_006E;         // 110 % of limit
   localparam logic [31:0] PHA_PCT_DIV = 32'h0000_0064;
   localparam logic [31:0] PHA_DCHG_STEP_MA = 32'h0000_0200;    // 512 mA
   localparam logic [31:0] PHA_DCHG_OFS_MA = 32'h0000_0080;     // 128 mA
   // System voltage thresholds in mV, index is the code
   localparam logic [15:0] PHA_SYSTEM_VOLTAGE_MULTI_MV [4] = '{16'h1676, 16'h1770, 16'h186A, 16'h1964};
   localparam logic [15:0] PHA_SYSTEM_VOLTAGE_SINGLE_MV [4] = '{16'h0B22, 16'h0C1C, 16'h0D16, 16'h0E10};
   // Times in ns and derived cycle counts at 4 ns per cycle
   localparam int PHA_CLK_NS = 4;
   localparam int PHA_T_15US_NS = 15000;
   localparam int PHA_T_20US_NS = 20000;
   localparam int PHA_T_100US_NS = 100000;
   localparam int PHA_T_400US_NS = 400000;
   localparam int PHA_T_800US_NS = 800000;
   localparam int PHA_T_1MS_NS = 1000000;
   localparam int PHA_T_1M6S_NS = 1600000;
   localparam int PHA_T_5MS_NS = 5000000;
   localparam int PHA_T_6MS_NS = 6000000;
   localparam int PHA_T_10MS_NS = 10000000;
   localparam int PHA_T_12MS_NS = 12000000;
   localparam int PHA_T_50MS_NS = 50000000;
   localparam int PHA_CYC_15US = PHA_T_15US_NS / PHA_CLK_NS;
   localparam int PHA_CYC_20US = PHA_T_20US_NS / PHA_CLK_NS;
   localparam int PHA_CYC_100US = PHA_T_100US_NS / PHA_CLK_NS;
   localparam int PHA_CYC_400US = PHA_T_400US_NS / PHA_CLK_NS;
   localparam int PHA_CYC_800US = PHA_T_800US_NS / PHA_CLK_NS;
   localparam int PHA_CYC_1MS = PHA_T_1MS_NS / PHA_CLK_NS;
   localparam int PHA_CYC_1M6S = PHA_T_1M6S_NS / PHA_CLK_NS;
   localparam int PHA_CYC_5MS = PHA_T_5MS_NS / PHA_CLK_NS;
   localparam int PHA_CYC_6MS = PHA_T_6MS_NS / PHA_CLK_NS;
   localparam int PHA_CYC_10MS = PHA_T_10MS_NS / PHA_CLK_NS;
   localparam int PHA_CYC_12MS = PHA_T_12MS_NS / PHA_CLK_NS;
   localparam int PHA_CYC_50MS = PHA_T_50MS_NS / PHA_CLK_NS;
   localparam int PHA_CNT_W = 24;
   // Alert output states
   typedef enum logic [1:0] {
      PHA_IDLE = 2'b00,
      PHA_MIN = 2'b01,
      PHA_HOLD = 2'b10,
      PHA_EXT = 2'b11
   } pha_state_t;
endpackage

// *** src/pha_monitor.sv ***
// Processor-hot alert monitor: thresholds, deglitch, alert pulse control
// Operation
// - Overload codes 1-25 give 110-230% limit
// - Codes 26-30 give 250-450%; 31 ignored
// - Critical level is 110% of overload
// - Critical deglitch 15/100/400/800 us by code
// - System undervoltage trips after 20 us deglitch
// - Voltage code picks threshold per cell count
// - Extension holds alert low until host clear
// - Minimum width 100us/1ms/10ms/5ms by code
// - Host writes clear zero to release alert
// - Nominal level is 110% of limit
// - Nominal deglitch 1 ms or 50 ms
// - Discharge level is code*512 plus 128 mA
// - Discharge current above level trips source
// - Discharge deglitch 1.6/0.1/6/12 ms by code
// - Profile bits gate sources; all zero disables
// - Battery removal gives one alert pulse
// - Adapter removal pulls alert low
`timescale 1ns/100ps
module pha_monitor #(
   parameter int TIME_DIV = 1, // Shrinks every time count together; 1 keeps real time
   parameter int CYC_15US = pha_pkg::PHA_CYC_15US / TIME_DIV,
   parameter int CYC_20US = pha_pkg::PHA_CYC_20US / TIME_DIV,
   parameter int CYC_100US = pha_pkg::PHA_CYC_100US / TIME_DIV,
   parameter int CYC_400US = pha_pkg::PHA_CYC_400US / TIME_DIV,
   parameter int CYC_800US = pha_pkg::PHA_CYC_800US / TIME_DIV,
   parameter int CYC_1MS = pha_pkg::PHA_CYC_1MS / TIME_DIV,
   parameter int CYC_1M6S = pha_pkg::PHA_CYC_1M6S / TIME_DIV,
   parameter int CYC_5MS = pha_pkg::PHA_CYC_5MS / TIME_DIV,
   parameter int CYC_6MS = pha_pkg::PHA_CYC_6MS / TIME_DIV,
   parameter int CYC_10MS = pha_pkg::PHA_CYC_10MS / TIME_DIV,
   parameter int CYC_12MS = pha_pkg::PHA_CYC_12MS / TIME_DIV,
   parameter int CYC_50MS = pha_pkg::PHA_CYC_50MS / TIME_DIV
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   input wire logic [15:0] input_current_ma,
   input wire logic [15:0] input_current_limit_ma,
   input wire logic [15:0] battery_discharge_current_ma,
   input wire logic [15:0] system_voltage_mv,
   input wire logic single_cell,
   input wire logic comparator_trip,
   input wire logic battery_present,
   input wire logic adapter_present,
   output logic processor_hot_alert_n
);
   import pha_pkg::*;
   localparam int SW = 68;
   localparam int CW = PHA_CNT_W;

   function automatic logic [CW-1:0] sel4(input logic [1:0] code, input int a, input int b, input int c, input int d);
      logic [CW-1:0] r;
      r = CW'(a);
      case (code)
         2'h1: r = CW'(b);
         2'h2: r = CW'(c);
         2'h3: r = CW'(d);
         default: r = CW'(a);
      endcase
      return r;
   endfunction

   logic [15:0] thresholds;
   logic [15:0] profile;
   logic [SW-1:0] sync_meta;
   logic [SW-1:0] sync_q;
   logic bat_prev;
   pha_state_t state;
   pha_state_t next_state;
   logic [CW-1:0] wcnt;
   logic [CW-1:0] width_need;
   logic [3:0] trip;
   logic [3:0] qual;
   logic [CW-1:0] need [4];
   logic [CW-1:0] cnt [4];
   logic [15:0] cur_s, lim_s, dchg_s, system_voltage_s;
   logic cell_s, comp_s, bat_s, ac_s;
   logic [4:0] ovl_code;
   logic ovl_valid;
   logic [31:0] ovl_pct, ovl_level, crit_level, nom_level, dchg_level;
   logic [15:0] system_voltage_level;
   logic [PHA_PROF_W-1:0] src;
   logic [PHA_PROF_W-1:0] prof_en;
   logic any_active;
   logic ext_en;
   logic clear_req;
   logic bat_fall;

   // Two-flop synchroniser on every analog-front-end input; the values move slowly
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sync_meta <= '0;
         sync_q <= '0;
      end else begin
         sync_meta <= {input_current_ma, input_current_limit_ma, battery_discharge_current_ma, system_voltage_mv,
                       single_cell, comparator_trip, battery_present, adapter_present};
         sync_q <= sync_meta;
      end
   end
   assign {cur_s, lim_s, dchg_s, system_voltage_s, cell_s, comp_s, bat_s, ac_s} = sync_q;

   // Register file; clear bit returns to idle one cycle after the host zeroes it
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         thresholds <= PHA_RST_THRESHOLDS;
         profile <= PHA_RST_PROFILE;
      end else begin
         // A profile write must not delay the clear bit's return to idle
         if (reg_wr && reg_addr == PHA_ADDR_THRESHOLDS) begin
            thresholds <= reg_wdata;
         end else if (!thresholds[PHA_CLEAR_BIT]) begin
            thresholds[PHA_CLEAR_BIT] <= 1'b1;
         end
         if (reg_wr && reg_addr == PHA_ADDR_PROFILE) begin
            profile <= reg_wdata;
         end
      end
   end

   // Read data; unmapped codes read zero
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            PHA_ADDR_THRESHOLDS: reg_rdata <= thresholds;
            PHA_ADDR_PROFILE: reg_rdata <= profile;
            default: reg_rdata <= '0;
         endcase
      end
   end

   // Overload percentage from the five-bit code; code zero treated as ignored too
   assign ovl_code = thresholds[PHA_OVL_LSB +: 5];
   always_comb begin
      ovl_valid = 1'b1;
      ovl_pct = '0;
      if (ovl_code == PHA_OVL_OUT_OF_RANGE || ovl_code == '0) begin
         ovl_valid = 1'b0;
      end else if (ovl_code <= PHA_OVL_FINE_LAST) begin
         ovl_pct = PHA_PCT_FINE_BASE + PHA_PCT_FINE_STEP * (32'(ovl_code) - 32'h1);
      end else begin
         ovl_pct = PHA_PCT_COARSE_BASE + PHA_PCT_COARSE_STEP * 32'(ovl_code - PHA_OVL_COARSE_FIRST);
      end
   end

   // Compare levels; 32-bit math keeps 450% of a 16-bit limit exact
   assign ovl_level = 32'(lim_s) * ovl_pct / PHA_PCT_DIV;
   assign crit_level = ovl_level * PHA_PCT_CRIT / PHA_PCT_DIV;
   assign nom_level = 32'(lim_s) * PHA_PCT_NOM / PHA_PCT_DIV;
   assign dchg_level = 32'(profile[PHA_DCHG_VTH_LSB +: 6]) * PHA_DCHG_STEP_MA + PHA_DCHG_OFS_MA;
   assign system_voltage_level = cell_s ? PHA_SYSTEM_VOLTAGE_SINGLE_MV[thresholds[PHA_SYSTEM_VOLTAGE_LSB +: 2]]
                              : PHA_SYSTEM_VOLTAGE_MULTI_MV[thresholds[PHA_SYSTEM_VOLTAGE_LSB +: 2]];

   // Raw trip conditions: 0 critical, 1 nominal, 2 discharge, 3 undervoltage
   assign trip[0] = ovl_valid && 32'(cur_s) > crit_level;
   assign trip[1] = 32'(cur_s) > nom_level;
   assign trip[2] = 32'(dchg_s) > dchg_level;
   assign trip[3] = system_voltage_s < system_voltage_level;
   assign need[0] = sel4(thresholds[PHA_CRIT_DEG_LSB +: 2], CYC_15US, CYC_100US, CYC_400US, CYC_800US);
   assign need[1] = thresholds[PHA_NOM_DEG_BIT] ? CW'(CYC_50MS) : CW'(CYC_1MS);
   assign need[2] = sel4(profile[PHA_DCHG_DEG_LSB +: 2], CYC_1M6S, CYC_100US, CYC_6MS, CYC_12MS);
   assign need[3] = CW'(CYC_20US);
   assign width_need = sel4(thresholds[PHA_WIDTH_LSB +: 2], CYC_100US, CYC_1MS, CYC_10MS, CYC_5MS);

   // Deglitch counters; any drop of the condition restarts the count
   for (genvar i = 0; i < 4; i++) begin : g_deg
      always_ff @(posedge ref_clk or posedge reset) begin
         if (reset) begin
            cnt[i] <= '0;
         end else if (!trip[i]) begin
            cnt[i] <= '0;
         end else if (cnt[i] < need[i]) begin // Saturates even if the time shrinks mid-count
            cnt[i] <= cnt[i] + 1'b1;
         end
      end
      assign qual[i] = trip[i] && cnt[i] >= need[i];
   end

   // Battery edge detector reads only the settled synchroniser stage
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         bat_prev <= 1'b0;
      end else begin
         bat_prev <= bat_s;
      end
   end
   assign bat_fall = bat_prev && !bat_s;

   // Source vector in profile bit order, gated by the profile
   assign src = {comp_s, qual[0], qual[1], qual[2], qual[3], bat_fall, !ac_s};
   assign prof_en = profile[PHA_PROF_W-1:0];
   assign any_active = |(src & prof_en);
   assign ext_en = thresholds[PHA_EXT_BIT];
   assign clear_req = !thresholds[PHA_CLEAR_BIT];

   // Alert sequencing; a source still active wins over a host clear
   always_comb begin
      next_state = state;
      case (state)
         PHA_IDLE: if (any_active) next_state = ext_en ? PHA_EXT : PHA_MIN;
         PHA_MIN: if (wcnt >= width_need - 1'b1) next_state = any_active ? PHA_HOLD : PHA_IDLE;
         PHA_HOLD: if (!any_active) next_state = PHA_IDLE;
         PHA_EXT: if (clear_req && !any_active) next_state = PHA_IDLE;
         default: next_state = PHA_IDLE;
      endcase
      if (prof_en == '0) begin
         next_state = PHA_IDLE;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state <= PHA_IDLE;
         processor_hot_alert_n <= 1'b1;
      end else begin
         state <= next_state;
         processor_hot_alert_n <= (next_state == PHA_IDLE);
      end
   end

   // Width counter runs only in the minimum-width state
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wcnt <= '0;
      end else if (state == PHA_MIN) begin
         wcnt <= wcnt + 1'b1;
      end else begin
         wcnt <= '0;
      end
   end

   sequence s_removed;
      prof_en[PHA_P_BAT] && bat_fall;
   endsequence
   sequence s_clear_ok;
      state == PHA_EXT && clear_req && !any_active && prof_en != '0;
   endsequence

   AST_DISABLED: assert property (@(posedge ref_clk) disable iff (reset) prof_en == '0 |=> processor_hot_alert_n)
      else $error("alert active with all profile bits zero");
   AST_BAT_PULSE: assert property (@(posedge ref_clk) disable iff (reset) s_removed |=> !processor_hot_alert_n)
      else $error("battery removal gave no alert");
   AST_EXT_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
      state == PHA_EXT && !clear_req && prof_en != '0 |=> !processor_hot_alert_n)
      else $error("extended alert released without clear");
   AST_CLEAR_RELEASE: assert property (@(posedge ref_clk) disable iff (reset)
      s_clear_ok |=> processor_hot_alert_n ##0 thresholds[PHA_CLEAR_BIT])
      else $error("host clear did not release alert");
   AST_MIN_WIDTH: assert property (@(posedge ref_clk) disable iff (reset)
      $rose(processor_hot_alert_n) |-> $past(state) != PHA_MIN || $past(wcnt) >= $past(width_need) - 1'b1
      || $past(prof_en) == '0)
      else $error("alert shorter than minimum width");
   AST_DEG_RESTART: assert property (@(posedge ref_clk) disable iff (reset) !trip[3] |=> cnt[3] == '0)
      else $error("deglitch count not restarted");
   AST_OOR_IGNORED: assert property (@(posedge ref_clk) disable iff (reset) ovl_code == PHA_OVL_OUT_OF_RANGE |-> !trip[0])
      else $error("out of range overload code compared");
   AST_FINE_FIRST: assert property (@(posedge ref_clk) disable iff (reset) ovl_code == 5'h01 |-> ovl_pct == PHA_PCT_FINE_BASE)
      else $error("first fine code not at base percentage");
   AST_HOLD_TRIPPED: assert property (@(posedge ref_clk) disable iff (reset)
      state == PHA_HOLD && any_active && prof_en != '0 |=> !processor_hot_alert_n && state == PHA_HOLD)
      else $error("alert released while a source is tripped");
   AST_SYSTEM_VOLTAGE_DEG: assert property (@(posedge ref_clk) disable iff (reset)
      $rose(qual[3]) |-> $past(cnt[3]) == CW'(CYC_20US) - 1'b1)
      else $error("undervoltage qualified before its deglitch");
endmodule // pha_monitor

// *** verif/pha_host_model.sv ***
// Host controller model issuing register commands toward the alert monitor
`timescale 1ns/100ps
module pha_host_model (
   input wire logic ref_clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata
);
   // Idle command lines at time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
   end
   // One write; lines scrambled on release so a stale value never looks valid
   task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= addr;
      reg_wdata <= data;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~addr;
      reg_wdata <= ~data;
   endtask
   // One read; data is registered one cycle after the request edge
   task automatic read_reg(input logic [7:0] addr, output logic [15:0] data);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= addr;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~addr;
      #1;
      data = reg_rdata;
   endtask
endmodule // pha_host_model

// *** verif/pha_monitor_tb_top.sv ***
// Self-checking bench for the processor-hot alert monitor
`timescale 1ns/100ps
module pha_monitor_tb_top;
   import pha_pkg::*;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic reg_wr, reg_rd;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, rd;
   logic [15:0] input_current_ma = 16'h0000;
   logic [15:0] input_current_limit_ma = 16'h03E8;
   logic [15:0] battery_discharge_current_ma = 16'h0000;
   logic [15:0] system_voltage_mv = 16'h2000;
   logic single_cell = 1'b0;
   logic comparator_trip = 1'b0;
   logic battery_present = 1'b1;
   logic adapter_present = 1'b1;
   logic processor_hot_alert_n;
   int fail_count = 0;
   int checks_done = 0;
   int cnt;
   localparam int DIV = 1250;
   localparam int WC[4] = '{PHA_CYC_100US / DIV, PHA_CYC_1MS / DIV, PHA_CYC_10MS / DIV, PHA_CYC_5MS / DIV};
   localparam int CD[4] = '{PHA_CYC_15US / DIV, PHA_CYC_100US / DIV, PHA_CYC_400US / DIV, PHA_CYC_800US / DIV};
   localparam int DD[4] = '{PHA_CYC_1M6S / DIV, PHA_CYC_100US / DIV, PHA_CYC_6MS / DIV, PHA_CYC_12MS / DIV};
   localparam logic [15:0] NL[2] = '{16'h03E8, 16'h07D0};
   localparam logic [4:0] OC[5] = '{5'h01, 5'h09, 5'h19, 5'h1A, 5'h1E};
   localparam logic [15:0] CL[5] = '{16'h04BA, 16'h0672, 16'h09E2, 16'h0ABE, 16'h1356};
   localparam logic [15:0] VT[8] = '{16'h1676, 16'h1770, 16'h186A, 16'h1964,
                                     16'h0B22, 16'h0C1C, 16'h0D16, 16'h0E10};
   // All time counts scaled down together so the run stays short; their ratios are kept
   pha_monitor #(.TIME_DIV(DIV)) pha_monitor_i (
      .ref_clk(ref_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .input_current_ma(input_current_ma),
      .input_current_limit_ma(input_current_limit_ma), .battery_discharge_current_ma(battery_discharge_current_ma),
      .system_voltage_mv(system_voltage_mv), .single_cell(single_cell), .comparator_trip(comparator_trip),
      .battery_present(battery_present), .adapter_present(adapter_present),
      .processor_hot_alert_n(processor_hot_alert_n));
   pha_host_model pha_host_model_i (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   // 250 MHz clock
   always #2 ref_clk = ~ref_clk;
   // Register images, clear bit left idle
   function automatic logic [15:0] th(logic [4:0] o, logic [1:0] cd, logic [1:0] v, logic e, logic [1:0] w, logic n);
      return {o, cd, 1'b0, v, e, w, 1'b1, n, 1'b0};
   endfunction
   function automatic logic [15:0] pf(logic [5:0] v, logic [1:0] d, logic [6:0] p);
      return {v, d, 1'b0, p};
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic ca(logic e);
      chk("alert", {15'h0000, e}, {15'h0000, processor_hot_alert_n});
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // Bounded wait for a given alert level; running out ends the run
   task automatic wait_lvl(logic lv, int n);
      for (int i = 0; i < n; i++) begin
         if (processor_hot_alert_n === lv) return;
         tick(1);
      end
      if (processor_hot_alert_n !== lv) begin
         ca(lv);
         summarize();
      end
   endtask
   task automatic quiet();
      @(posedge ref_clk);
      input_current_ma <= 16'h0000;
      battery_discharge_current_ma <= 16'h0000;
      system_voltage_mv <= 16'h2000;
      comparator_trip <= 1'b0;
      battery_present <= 1'b1;
      adapter_present <= 1'b1;
      wait_lvl(1'b1, 60);
   endtask
   task automatic rchk(logic [7:0] a, logic [15:0] e);
      pha_host_model_i.read_reg(a, rd);
      chk("register", e, rd);
   endtask
   // Trip set at the last edge: two sync edges, n counting edges, then the alert edge
   task automatic probe(int n);
      tick(n + 2);
      ca(1'b1);
      tick(1);
      ca(1'b0);
      quiet();
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      reset <= 1'b0;
      tick(1);
      ca(1'b1);
      rchk(PHA_ADDR_THRESHOLDS, 16'h4A54);
      rchk(PHA_ADDR_PROFILE, 16'h8120);
      rchk(8'h35, 16'h0000);
      pha_host_model_i.write_reg(PHA_ADDR_THRESHOLDS, 16'h4A50);
      rchk(PHA_ADDR_THRESHOLDS, 16'h4A54);
      // Minimum pulse width for each code, started by battery removal
      pha_host_model_i.write_reg(PHA_ADDR_PROFILE, pf(6'h20, 2'h1, 7'h02));
      for (int w = 0; w < 4; w++) begin
         pha_host_model_i.write_reg(PHA_ADDR_THRESHOLDS, th(5'h09, 2'h1, 2'h1, 1'b0, w[1:0], 1'b0));
         @(posedge ref_clk);
         battery_present <= 1'b0;
         wait_lvl(1'b0, 10);
         cnt = 1;
         repeat (WC[w] + 8) begin
            tick(1);
            if (processor_hot_alert_n === 1'b0) cnt++;
         end
         chk("width", 16'(WC[w]), cnt[15:0]);
         quiet();
      end
      // Extension holds until the host clear
      pha_host_model_i.write_reg(PHA_ADDR_THRESHOLDS, th(5'h09, 2'h1, 2'h1, 1'b1, 2'h0, 1'b0));
      @(posedge ref_clk);
      battery_present <= 1'b0;
      wait_lvl(1'b0, 10);
      tick(30);
      ca(1'b0);
      pha_host_model_i.write_reg(PHA_ADDR_THRESHOLDS, th(5'h09, 2'h1, 2'h1, 1'b1, 2'h0, 1'b0) & 16'hFFFB);
      wait_lvl(1'b1, 4);
      quiet();
      // Critical level per overload code, then deglitch per code
      pha_host_model_i.write_reg(PHA_ADDR_PROFILE, pf(6'h20, 2'h1, 7'h20));
      for (int i = 0; i < 5; i++) begin
         pha_host_model_i.write_reg(PHA_ADDR_THRESHOLDS, th(OC[i], 2'h0, 2'h1, 1'b0, 2'h0, 1'b0));
         @(posedge ref_clk);
         input_current_ma <= CL[i];
         tick(14);
         ca(1'b1);
         @(posedge ref_clk);
         input_current_ma <= CL[i] + 16'h0001;
         probe(PHA_CYC_15US / DIV);
      end
      // Out-of-range code and code zero both leave the critical compare off
      for (int k = 0; k < 2; k++) begin
         pha_host_model_i.write_reg(PHA_ADDR_THRESHOLDS, th(k == 0 ? 5'h1F : 5'h00, 2'h0, 2'h1, 1'b0, 2'h0, 1'b0));
         @(posedge ref_clk);
         input_current_ma <= 16'hFFFF;
         tick(20);
         ca(1'b1);
         quiet();
      end
      for (int d = 0; d < 4; d++) begin
         pha_host_model_i.write_reg(PHA_ADDR_THRESHOLDS, th(5'h09, d[1:0], 2'h1, 1'b0, 2'h0, 1'b0));
         @(posedge ref_clk);
         input_current_ma <= 16'h0673;
         probe(CD[d]);
      end
      // Nominal level, both deglitch times, and a restart after a dropout
      pha_host_model_i.write_reg(PHA_ADDR_PROFILE, pf(6'h20, 2'h1, 7'h10));
      for (int n = 0; n < 2; n++) begin
         pha_host_model_i.write_reg(PHA_ADDR_THRESHOLDS, th(5'h09, 2'h1, 2'h1, 1'b0, 2'h0, n[0]));
         @(posedge ref_clk);
         input_current_limit_ma <= NL[n];
         input_current_ma <= NL[n] + NL[n] / 16'h000A;
         tick(20);
         ca(1'b1);
         @(posedge ref_clk);
         input_current_ma <= NL[n] + NL[n] / 16'h000A + 16'h0001;
         probe(n == 0 ? PHA_CYC_1MS / DIV : PHA_CYC_50MS / DIV);
      end
      // One-cycle dropout halfway through the count must restart it
      pha_host_model_i.write_reg(PHA_ADDR_THRESHOLDS, th(5'h09, 2'h1, 2'h1, 1'b0, 2'h0, 1'b0));
      @(posedge ref_clk);
      input_current_limit_ma <= NL[0];
      input_current_ma <= 16'h044D;
      repeat (PHA_CYC_1MS / DIV / 2) @(posedge ref_clk);
      input_current_ma <= 16'h0000;
      @(posedge ref_clk);
      input_current_ma <= 16'h044D;
      probe(PHA_CYC_1MS / DIV);
      // Discharge level and deglitch per code
      for (int d = 0; d < 4; d++) begin
         pha_host_model_i.write_reg(PHA_ADDR_PROFILE, pf(6'h20, d[1:0], 7'h08));
         @(posedge ref_clk);
         battery_discharge_current_ma <= 16'h4080;
         tick(20);
         ca(1'b1);
         @(posedge ref_clk);
         battery_discharge_current_ma <= 16'h4081;
         probe(DD[d]);
      end
      // System voltage thresholds for both cell counts
      pha_host_model_i.write_reg(PHA_ADDR_PROFILE, pf(6'h20, 2'h1, 7'h04));
      for (int v = 0; v < 8; v++) begin
         pha_host_model_i.write_reg(PHA_ADDR_THRESHOLDS, th(5'h09, 2'h1, v[1:0], 1'b0, 2'h0, 1'b0));
         @(posedge ref_clk);
         single_cell <= v[2];
         system_voltage_mv <= VT[v];
         tick(14);
         ca(1'b1);
         @(posedge ref_clk);
         system_voltage_mv <= VT[v] - 16'h0001;
         probe(PHA_CYC_20US / DIV);
      end
      // Adapter removal holds the alert; the comparator trips at once
      pha_host_model_i.write_reg(PHA_ADDR_PROFILE, pf(6'h20, 2'h1, 7'h41));
      @(posedge ref_clk);
      adapter_present <= 1'b0;
      wait_lvl(1'b0, 8);
      tick(20);
      ca(1'b0);
      quiet();
      @(posedge ref_clk);
      comparator_trip <= 1'b1;
      wait_lvl(1'b0, 6);
      quiet();
      // All profile bits clear: nothing may raise the alert
      pha_host_model_i.write_reg(PHA_ADDR_PROFILE, pf(6'h00, 2'h1, 7'h00));
      @(posedge ref_clk);
      adapter_present <= 1'b0;
      battery_present <= 1'b0;
      comparator_trip <= 1'b1;
      system_voltage_mv <= 16'h0000;
      input_current_ma <= 16'hFFFF;
      battery_discharge_current_ma <= 16'hFFFF;
      tick(40);
      ca(1'b1);
      summarize();
   end
endmodule // pha_monitor_tb_top
